// file: hdl/e2tif_frame_timer.sv
/*
  e2tif_frame_timer: bit position counter within one frame.
  Assumes: step is a one-cycle pulse per bit period; restart wins over wrap.
*/
`timescale 1ns/1ps
module e2tif_frame_timer #(
  parameter int unsigned FRAME_BITS = e2tif_pkg::FRAME_BITS,
  parameter int unsigned PW = $clog2(FRAME_BITS)
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // control
  input wire logic step,
  input wire logic restart,
  // position of the current bit
  output logic [PW-1:0] pos_q
);
  import e2tif_pkg::*;

  typedef struct packed {
    logic [PW-1:0] pos;
  } e2tif_tmr_s;

  localparam logic [PW-1:0] LAST_POS = PW'(FRAME_BITS - 1);
  localparam logic [PW-1:0] POS_ONE = PW'(1);

  e2tif_tmr_s st_q, st_d;

  // ==========================================================================
  // next position: restart marks the bit after frame start
  always_comb begin
    st_d = st_q;
    if (step) begin
      if (restart) begin
        st_d.pos = POS_ONE;
      end else if (st_q.pos == LAST_POS) begin
        st_d.pos = '0;
      end else begin
        st_d.pos = st_q.pos + POS_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pos_q = st_q.pos;
endmodule

// file: hdl/e2tif_pkg.sv
/*
  e2tif_pkg: shared constants of the terminal-side interface of the line framer.
  Assumes: imported by e2tif_top, e2tif_frame_timer, e2tif_partner and tb; no software access.
*/
// Function
// (RULE_01) Sample line data, dual rail or NRZ, on the receive line clock.
// (RULE_02) Derive receive nibble and serial clocks from the receive line clock.
// (RULE_03) Gap receive nibble clock over framing, service and BIP-4 bit times.
// (RULE_04) Never show framing, service or BIP-4 bits on receive nibble outputs.
// (RULE_05) Receive nibble bit 3 is first received, bit 0 last received.
// (RULE_06) Serial receive data carries every frame bit, overhead included.
// (RULE_07) Receive frame pulse: last nibble in nibble mode, first bit serial.
// (RULE_08) Serial mode only: receive gap marker low at framing and service bits.
// (RULE_09) Line transmit clock comes from terminal transmit clock and clocks data.
// (RULE_10) External source puts first transmitted bit of each nibble on bit 3.
// (RULE_11) External source drives active-low serial frame pulse at first bit.
// (RULE_12) Shared pins: nibble bits, or reference data one at framing bits.
// (RULE_13) Reference gap output low at framing and service bits, high elsewhere.
// (RULE_14) Reference frame output pulses low at the first bit of each frame.
// (RULE_15) Serial mode reference outputs all derive from the reference clock input.
// (RULE_16) Transmit nibble clock from terminal clock, gapped over overhead and BIP-4.
// (RULE_17) Nibble mode: active-low transmit frame pulse marks first frame bit.
// (RULE_18) Reference clock output follows reference clock input, same duty cycle.
// (RULE_19) Static mode input selects nibble or serial and sets shared pin functions.
package e2tif_pkg;
  // ==========================================================================
  // frame layout
  localparam int unsigned FRAME_BITS = 848; // bits per frame
  localparam int unsigned FAS_BITS = 10; // framing pattern at frame start
  localparam int unsigned SVC_BITS = 2; // service bits after the pattern
  localparam int unsigned BIP_BITS = 4; // parity nibble at frame end, 0 if absent
  localparam logic [9:0] FAS_PATTERN = 10'h3D0; // sent msb first
  localparam int unsigned NIB_BITS = 4;
  // ==========================================================================
  // positions inside a nibble
  localparam logic [1:0] NIB_FIRST = 2'h0;
  localparam logic [1:0] NIB_CLK_AT = 2'h2; // raise request one bit before last
  localparam logic [1:0] NIB_LAST = 2'h3;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  // ==========================================================================
  // terminal mode codes
  localparam logic MODE_NIBBLE = 1'b0;
  localparam logic MODE_SERIAL = 1'b1;
endpackage

// file: hdl/e2tif_top.sv
/*
  e2tif_top: terminal-side data interface, receive and transmit paths plus
  the serial-mode transmit reference generator.
  Assumes: all pin clocks are far slower than sys_clk (at most sys_clk/6),
  frame alignment is done elsewhere so the receive timer free-runs, line
  coding is done elsewhere so the rails carry plain data.
*/
`timescale 1ns/1ps
module e2tif_top #(
  parameter int unsigned FRAME_BITS = e2tif_pkg::FRAME_BITS,
  parameter int unsigned FAS_BITS = e2tif_pkg::FAS_BITS,
  parameter int unsigned SVC_BITS = e2tif_pkg::SVC_BITS,
  parameter int unsigned BIP_BITS = e2tif_pkg::BIP_BITS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // static configuration
  input wire logic serial_mode_sel,
  input wire logic dual_rail_sel,
  // line receive
  input wire logic line_rx_pos_rail_or_nrz,
  input wire logic line_rx_neg_rail,
  input wire logic line_rx_clock,
  // line transmit
  output logic line_tx_pos_rail_or_nrz,
  output logic line_tx_neg_rail,
  output logic line_tx_clock,
  // terminal receive and reference generator outputs
  output logic rx_serial_gap_marker,
  output logic rx_frame_pulse,
  output logic rx_nibble_msb_or_serial_data,
  output logic rx_nibble_b2_or_refgen_data,
  output logic rx_nibble_b1_or_refgen_gap,
  output logic rx_nibble_lsb_or_refgen_frame,
  output logic rx_nibble_or_serial_clock,
  // terminal transmit
  input wire logic tx_nibble_msb_or_serial_frame,
  input wire logic tx_nibble_b2,
  input wire logic tx_nibble_b1_or_refgen_clk_in,
  input wire logic tx_nibble_lsb_or_serial_data,
  input wire logic terminal_tx_clock,
  output logic tx_nibble_frame_pulse,
  output logic tx_nibble_clock_or_refgen_clk_out
);
  import e2tif_pkg::*;

  localparam int unsigned PW = $clog2(FRAME_BITS);
  localparam logic [PW-1:0] OVH_END = PW'(FAS_BITS + SVC_BITS);
  localparam logic [PW-1:0] FAS_END = PW'(FAS_BITS);
  localparam logic [PW-1:0] BIP_START = PW'(FRAME_BITS - BIP_BITS);
  localparam logic [PW-1:0] LAST_NIB = PW'(FRAME_BITS - BIP_BITS - 1);

  typedef struct packed {
    // two-stage synchronisers: m is read only by s
    logic [5:0] in_m;
    logic [5:0] in_s;
    logic [3:0] nib_m;
    logic [3:0] nib_s;
    logic rxclk_p;
    logic txclk_p;
    logic rgclk_p;
    // receive path
    logic [2:0] rx_sh;
    logic rx_nclk;
    // transmit path
    logic [3:0] tx_sh;
    // registered pins
    logic o_gap;
    logic o_fp;
    logic o_b3;
    logic o_b2;
    logic o_b1;
    logic o_b0;
    logic o_clk;
    logic o_tdat;
    logic o_tclk;
    logic o_tnfp;
    logic o_tnclk;
  } e2tif_st_s;

  e2tif_st_s st_q, st_d;
  logic [PW-1:0] rx_pos, tx_pos, rg_pos;
  logic rx_step, tx_step, rg_step, tx_restart;
  logic mode, rxclk, txclk, rgclk, rxdat, xsd, xsf_n;

  // synchronised pin levels, named for readability
  assign rxclk = st_q.in_s[0];
  assign rxdat = st_q.in_s[5] ? (st_q.in_s[1] | st_q.in_s[2]) : st_q.in_s[1]; // RULE_01
  assign txclk = st_q.in_s[3];
  assign mode = st_q.in_s[4];
  assign rgclk = st_q.nib_s[1];
  assign xsd = st_q.nib_s[0];
  assign xsf_n = st_q.nib_s[3];

  // rising edges of the three pin clocks, each one-cycle step enable
  assign rx_step = rxclk & ~st_q.rxclk_p; // RULE_01
  assign tx_step = txclk & ~st_q.txclk_p; // RULE_09
  assign rg_step = rgclk & ~st_q.rgclk_p & (mode == MODE_SERIAL); // RULE_15
  // serial source frame pulse (low at first bit) realigns the transmit frame
  assign tx_restart = (mode == MODE_SERIAL) & ~xsf_n; // RULE_11

  // ==========================================================================
  // frame position counters, one per timing source
  e2tif_frame_timer #(.FRAME_BITS(FRAME_BITS), .PW(PW)) u_rx_tmr (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .step(rx_step),
    .restart(1'b0),
    .pos_q(rx_pos)
  );

  e2tif_frame_timer #(.FRAME_BITS(FRAME_BITS), .PW(PW)) u_tx_tmr (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .step(tx_step),
    .restart(tx_restart),
    .pos_q(tx_pos)
  );

  e2tif_frame_timer #(.FRAME_BITS(FRAME_BITS), .PW(PW)) u_rg_tmr (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .step(rg_step),
    .restart(1'b0),
    .pos_q(rg_pos)
  );

  // overhead = framing pattern, service bits or parity nibble
  function automatic logic is_ovh(input logic [PW-1:0] p);
    is_ovh = (p < OVH_END) || (p >= BIP_START);
  endfunction

  // index of a payload bit inside its nibble
  function automatic logic [1:0] nib_idx(input logic [PW-1:0] p);
    logic [PW-1:0] off;
    off = p - OVH_END;
    nib_idx = off[1:0];
  endfunction

  // ==========================================================================
  // next-state logic of the whole block
  always_comb begin
    st_d = st_q;
    st_d.in_m = {dual_rail_sel, serial_mode_sel, terminal_tx_clock, line_rx_neg_rail,
                 line_rx_pos_rail_or_nrz, line_rx_clock};
    st_d.in_s = st_q.in_m;
    st_d.nib_m = {tx_nibble_msb_or_serial_frame, tx_nibble_b2,
                  tx_nibble_b1_or_refgen_clk_in, tx_nibble_lsb_or_serial_data};
    st_d.nib_s = st_q.nib_m;
    st_d.rxclk_p = rxclk;
    st_d.txclk_p = txclk;
    st_d.rgclk_p = rgclk;

    // receive side: everything steps on a line receive clock edge
    if (rx_step) begin
      st_d.rx_nclk = 1'b0; // nibble clock is high for one bit period
      if (mode == MODE_NIBBLE) begin
        st_d.o_gap = 1'b1;
        // overhead bits are dropped, so the nibble clock gaps over them
        if (!is_ovh(rx_pos)) begin // RULE_03 RULE_04
          st_d.rx_sh = {st_q.rx_sh[1:0], rxdat};
          if (nib_idx(rx_pos) == NIB_LAST) begin
            // first received bit lands on bit 3
            {st_d.o_b3, st_d.o_b2, st_d.o_b1} = st_q.rx_sh; // RULE_05
            st_d.o_b0 = rxdat; // RULE_05
            st_d.rx_nclk = 1'b1; // RULE_02 RULE_03
            st_d.o_fp = (rx_pos == LAST_NIB); // RULE_07
          end
        end
      end else begin
        st_d.o_b3 = rxdat; // RULE_06
        st_d.o_fp = (rx_pos == '0); // RULE_07
        st_d.o_gap = !(rx_pos < OVH_END); // RULE_08
      end
    end

    // reference generator: phase follows its own clock input
    if (rg_step) begin
      st_d.o_b2 = (rg_pos < FAS_END); // RULE_12
      st_d.o_b1 = !(rg_pos < OVH_END); // RULE_13
      st_d.o_b0 = (rg_pos != '0); // RULE_14
    end

    // shared clock pin: nibble clock, or the serial clock copied from line
    st_d.o_clk = (mode == MODE_NIBBLE) ? st_q.rx_nclk : rxclk; // RULE_02 RULE_19
    if (mode == MODE_NIBBLE) begin
      st_d.o_gap = 1'b1; // marker is a serial-only signal
    end

    // transmit side: line clock is a delayed copy of the terminal clock
    st_d.o_tclk = txclk; // RULE_09
    if (tx_step) begin
      if (mode == MODE_NIBBLE) begin
        if (tx_pos < FAS_END) begin
          st_d.o_tdat = FAS_PATTERN[4'(FAS_BITS - 1) - 4'(tx_pos)];
        end else if (is_ovh(tx_pos)) begin
          st_d.o_tdat = 1'b0; // service and parity insertion lives elsewhere
        end else if (nib_idx(tx_pos) == NIB_FIRST) begin
          // source placed the first bit to send on bit 3
          st_d.o_tdat = st_q.nib_s[3]; // RULE_10
          st_d.tx_sh = {st_q.nib_s[2:0], 1'b0};
        end else begin
          st_d.o_tdat = st_q.tx_sh[3];
          st_d.tx_sh = {st_q.tx_sh[2:0], 1'b0};
        end
        // request the next nibble one bit early so it settles before use
        st_d.o_tnclk = !is_ovh(tx_pos) && (nib_idx(tx_pos) == NIB_CLK_AT); // RULE_16
        st_d.o_tnfp = (tx_pos != '0); // RULE_17
      end else begin
        st_d.o_tdat = xsd; // RULE_09
        st_d.o_tnfp = 1'b1;
        st_d.o_tnclk = 1'b0;
      end
    end
    // shared transmit clock pin: refgen copy keeps the input duty cycle
    if (mode == MODE_SERIAL) begin
      st_d.o_tnclk = rgclk; // RULE_18 RULE_19
    end
  end

  // ==========================================================================
  // state register; idle levels keep active-low pulses inactive
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
      st_q.o_gap <= 1'b1;
      st_q.o_b0 <= 1'b1;
      st_q.o_b1 <= 1'b1;
      st_q.o_tnfp <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // pins, all straight from flip-flops except the constant negative transmit rail
  assign line_tx_pos_rail_or_nrz = st_q.o_tdat;
  assign line_tx_neg_rail = 1'b0; // no line coding in this block
  assign line_tx_clock = st_q.o_tclk;
  assign rx_serial_gap_marker = st_q.o_gap;
  assign rx_frame_pulse = st_q.o_fp;
  assign rx_nibble_msb_or_serial_data = st_q.o_b3;
  assign rx_nibble_b2_or_refgen_data = st_q.o_b2;
  assign rx_nibble_b1_or_refgen_gap = st_q.o_b1;
  assign rx_nibble_lsb_or_refgen_frame = st_q.o_b0;
  assign rx_nibble_or_serial_clock = st_q.o_clk;
  assign tx_nibble_frame_pulse = st_q.o_tnfp;
  assign tx_nibble_clock_or_refgen_clk_out = st_q.o_tnclk;
endmodule

// file: verification/e2tif_assertions.sv
/*
  e2tif_assertions: port-level checker for e2tif_top.
  Assumes: pin clocks at most sys_clk/6, mode changed only under reset.
*/
`timescale 1ns/1ps
module e2tif_assertions (
  // clock and reset
  input logic sys_clk,
  input logic arst_n,
  // watched pins
  input logic serial_mode_sel,
  input logic line_rx_clock,
  input logic terminal_tx_clock,
  input logic tx_nibble_b1_or_refgen_clk_in,
  input logic line_tx_clock,
  input logic rx_serial_gap_marker,
  input logic rx_frame_pulse,
  input logic rx_nibble_msb_or_serial_data,
  input logic rx_nibble_b2_or_refgen_data,
  input logic rx_nibble_b1_or_refgen_gap,
  input logic rx_nibble_lsb_or_refgen_frame,
  input logic rx_nibble_or_serial_clock,
  input logic tx_nibble_frame_pulse,
  input logic tx_nibble_clock_or_refgen_clk_out
);
  logic ser;
  logic [3:0] nib;
  assign ser = serial_mode_sel;
  assign nib = {rx_nibble_msb_or_serial_data, rx_nibble_b2_or_refgen_data,
    rx_nibble_b1_or_refgen_gap, rx_nibble_lsb_or_refgen_frame};
  default clocking d_clk @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // receive side
  a_gap_nibble_high: assert property (!ser |-> rx_serial_gap_marker)
    else $error("gap marker low in nibble mode");
  a_rxfp_in_gap: assert property (ser && rx_frame_pulse |-> !rx_serial_gap_marker)
    else $error("serial frame pulse outside gap");
  a_rxclk_follow: assert property (ser && $rose(line_rx_clock)
    |-> ##[2:5] $rose(rx_nibble_or_serial_clock)) else $error("serial clock late");
  a_nib_stable: assert property (!ser && $rose(rx_nibble_or_serial_clock)
    |-> $stable(nib) [*4]) else $error("nibble moved while clocked");
  // ==========================================================================
  // reference generator and transmit side
  a_ref_frame_pos: assert property (ser && !rx_nibble_lsb_or_refgen_frame
    |-> rx_nibble_b2_or_refgen_data && !rx_nibble_b1_or_refgen_gap)
    else $error("reference frame pulse off frame bit");
  a_ref_data_gap: assert property (ser && rx_nibble_b2_or_refgen_data
    |-> !rx_nibble_b1_or_refgen_gap) else $error("reference data outside gap");
  a_refclk_rise: assert property (ser && $rose(tx_nibble_b1_or_refgen_clk_in)
    |-> ##[1:6] $rose(tx_nibble_clock_or_refgen_clk_out)) else $error("ref clock rise lost");
  a_refclk_fall: assert property (ser && $fell(tx_nibble_b1_or_refgen_clk_in)
    |-> ##[1:6] $fell(tx_nibble_clock_or_refgen_clk_out)) else $error("ref clock fall lost");
  a_txfp_serial_idle: assert property (ser |-> tx_nibble_frame_pulse)
    else $error("transmit frame pulse in serial mode");
  a_ltx_clk_follow: assert property ($rose(terminal_tx_clock)
    |-> ##[2:5] $rose(line_tx_clock)) else $error("line clock late");
endmodule

bind e2tif_top e2tif_assertions u_chk (.*);

// file: verification/e2tif_partner.sv
/*
  e2tif_partner: external payload multiplexer on the terminal transmit side.
  Assumes: device samples these pins through synchronisers; mode static.
*/
`timescale 1ns/1ps
module e2tif_partner (
  // clock and mode
  input logic sys_clk,
  input logic serial_mode_sel,
  // from the device
  input logic tx_nibble_clock_or_refgen_clk_out,
  // to the device, pin 3 first transmitted in nibble mode, serial frame pulse in serial mode
  output logic terminal_tx_clock,
  output logic [3:0] tx_pins
);
  import e2tif_pkg::*;
  integer seed = 21;
  int cnt = 0;
  int pos = 0;
  logic nclk_q = 1'b0;
  logic [3:0] nib;
  logic [3:0] exp_q[$];
  initial begin
    terminal_tx_clock = 1'b0;
    tx_pins = 4'h0;
  end
  // ==========================================================================
  // 3 high, 7 low: an uneven duty shows whether a copied clock keeps it
  always @(negedge sys_clk) begin
    cnt <= (cnt == 9) ? 0 : cnt + 1;
    terminal_tx_clock <= (cnt < 3);
    nclk_q <= tx_nibble_clock_or_refgen_clk_out;
    if (serial_mode_sel) begin
      tx_pins[1] <= (cnt < 3);
      // data moves mid low phase, far from the sampling edge
      if (cnt == 6) begin
        pos <= (pos == FRAME_BITS - 1) ? 0 : pos + 1;
        tx_pins[3] <= (pos != 0);
        nib = 4'($random(seed));
        tx_pins[0] <= nib[0];
        exp_q.push_back(nib);
      end
    end else if (tx_nibble_clock_or_refgen_clk_out && !nclk_q) begin
      nib = 4'($random(seed));
      tx_pins <= nib;
      exp_q.push_back(nib);
    end
  end
endmodule

// file: verification/tb.sv
/*
  tb: self-checking bench for e2tif_top with the transmit-side partner.
  Assumes: default frame layout; rx clock stands still outside bursts.
*/
`timescale 1ns/1ps
module tb;
  import e2tif_pkg::*;
  logic sys_clk, arst_n, serial_mode_sel, dual_rail_sel, line_rx_pos_rail_or_nrz;
  logic line_rx_neg_rail, line_rx_clock, line_tx_pos_rail_or_nrz, line_tx_neg_rail;
  logic line_tx_clock, rx_serial_gap_marker, rx_frame_pulse, rx_nibble_msb_or_serial_data;
  logic rx_nibble_b2_or_refgen_data, rx_nibble_b1_or_refgen_gap, rx_nibble_lsb_or_refgen_frame;
  logic rx_nibble_or_serial_clock, tx_nibble_frame_pulse, tx_nibble_clock_or_refgen_clk_out;
  logic terminal_tx_clock, texp;
  logic [3:0] tx_pins, tnib;
  logic [3:0] h_rx, h_ref, h_tx, h_pin;
  logic [5:0] h_seen;
  logic [5:0] rx_q[$];
  logic [5:0] ref_q[$];
  integer seed = 21;
  int n_mismatch = 0;
  int cmp_count = 0;
  int tpos = -1;
  int rpos = 0;
  e2tif_top u_dut (.*, .tx_nibble_msb_or_serial_frame(tx_pins[3]), .tx_nibble_b2(tx_pins[2]),
    .tx_nibble_b1_or_refgen_clk_in(tx_pins[1]), .tx_nibble_lsb_or_serial_data(tx_pins[0]));
  e2tif_partner u_far (.*);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // reporting
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================================
  // receive line driver: 8-cycle bits, data moves while the clock is low
  task automatic rx_bits(input int n);
    logic b, r;
    logic [3:0] nib;
    int p;
    for (int k = 0; k < n; k++) begin
      p = k % FRAME_BITS;
      b = 1'($random(seed));
      r = 1'($random(seed));
      nib = {nib[2:0], b};
      line_rx_pos_rail_or_nrz = dual_rail_sel ? (b & r) : b;
      line_rx_neg_rail = dual_rail_sel ? (b & !r) : r; // noise when unused
      repeat (4) @(negedge sys_clk);
      line_rx_clock = 1'b1;
      if (serial_mode_sel) rx_q.push_back({3'b0, b, p >= FAS_BITS + SVC_BITS, p == 0});
      else if (p >= 12 && p < FRAME_BITS - BIP_BITS && p % 4 == 3)
        rx_q.push_back({1'b0, p == FRAME_BITS - BIP_BITS - 1, nib});
      repeat (4) @(negedge sys_clk);
      line_rx_clock = 1'b0;
    end
  endtask
  task automatic run_test(input logic mode, input logic rail);
    arst_n = 1'b0;
    serial_mode_sel = mode;
    dual_rail_sel = rail;
    rx_q.delete();
    ref_q.delete();
    tpos = -1;
    repeat (10) @(negedge sys_clk);
    // release while the partner clock is low so no edge straddles it
    @(negedge terminal_tx_clock);
    @(negedge sys_clk);
    // drop notes made under reset; the first nibble after reset is the idle pin value
    u_far.exp_q.delete();
    if (!mode) u_far.exp_q.push_back(u_far.tx_pins);
    arst_n = 1'b1;
    rx_bits(FRAME_BITS + 16);
    repeat (40) @(negedge sys_clk);
    check(6'(rx_q.size()), 6'h00);
    $display("test mode %0d rail %0d done", mode, rail);
  endtask
  // ==========================================================================
  // output watchers sample mid-bit, two cycles after a clock output rises
  always @(posedge sys_clk) begin
    h_rx <= {h_rx[2:0], rx_nibble_or_serial_clock};
    h_ref <= {h_ref[2:0], tx_nibble_clock_or_refgen_clk_out};
    h_tx <= {h_tx[2:0], line_tx_clock};
    h_pin <= {h_pin[2:0], tx_pins[1]};
    if (!arst_n) rpos = 0;
    if (arst_n && serial_mode_sel && h_pin[1:0] == 2'b01) begin
      ref_q.push_back({3'b0, rpos < FAS_BITS, rpos >= FAS_BITS + SVC_BITS, rpos != 0});
      rpos = (rpos + 1) % FRAME_BITS;
    end
    if (arst_n && h_rx[2:1] == 2'b01) begin
      h_seen = serial_mode_sel ? {3'b0, rx_nibble_msb_or_serial_data, rx_serial_gap_marker,
        rx_frame_pulse} : {1'b0, rx_frame_pulse, rx_nibble_msb_or_serial_data,
        rx_nibble_b2_or_refgen_data, rx_nibble_b1_or_refgen_gap, rx_nibble_lsb_or_refgen_frame};
      check(h_seen, rx_q.size() ? rx_q.pop_front() : 6'h3F);
    end
    if (arst_n && serial_mode_sel && h_ref[2:1] == 2'b01) begin
      h_seen = {3'b0, rx_nibble_b2_or_refgen_data, rx_nibble_b1_or_refgen_gap,
        rx_nibble_lsb_or_refgen_frame};
      check(h_seen, ref_q.size() ? ref_q.pop_front() : 6'h3F);
    end
    if (arst_n && !serial_mode_sel && h_tx[2:1] == 2'b01) begin
      if (!tx_nibble_frame_pulse) tpos = 0;
      if (tpos >= 0 && tpos < FRAME_BITS - BIP_BITS) begin
        if (tpos >= FAS_BITS + SVC_BITS && (tpos - 12) % 4 == 0)
          tnib = u_far.exp_q.size() ? u_far.exp_q.pop_front() : 4'hx;
        if (tpos < FAS_BITS) texp = FAS_PATTERN[FAS_BITS - 1 - tpos];
        else if (tpos < FAS_BITS + SVC_BITS) texp = 1'b0;
        else texp = tnib[3 - (tpos - 12) % 4];
        check(6'({line_tx_neg_rail, line_tx_pos_rail_or_nrz}), 6'({1'b0, texp}));
      end
      if (tpos >= 0) tpos = (tpos + 1) % FRAME_BITS;
    end
    // serial transmit: each line clock rise carries the bit the source last set
    if (arst_n && serial_mode_sel && h_tx[2:1] == 2'b01) begin
      tnib = u_far.exp_q.size() ? u_far.exp_q.pop_front() : 4'hx;
      check(6'({line_tx_neg_rail, line_tx_pos_rail_or_nrz}), 6'({1'b0, tnib[0]}));
    end
  end
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    arst_n = 1'b0;
    serial_mode_sel = 1'b0;
    dual_rail_sel = 1'b0;
    line_rx_pos_rail_or_nrz = 1'b0;
    line_rx_neg_rail = 1'b0;
    line_rx_clock = 1'b0;
    run_test(1'b0, 1'b0);
    run_test(1'b1, 1'b1);
    complete_run();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    complete_run();
  end
endmodule
